// >>> rtl/rco_consts.vh
// Constants for the reference clock output block.
// Assumes byte addressing on a 32-bit classic Wishbone bus.
`ifndef RCO_CONSTS_VH
`define RCO_CONSTS_VH

// ==========================================
// Register offsets
`define RCO_ADR_W 4
`define RCO_CTRL_ADR 4'h0
`define RCO_SRC_ADR 4'h4

// ==========================================
// Control register fields
`define RCO_EN_BIT 7
`define RCO_DUTY_HI 4
`define RCO_DUTY_LO 3
`define RCO_DIV_HI 2
`define RCO_DIV_LO 0
`define RCO_CTRL_MASK 8'h9f
`define RCO_CTRL_RST 8'h10

// ==========================================
// Source register fields
`define RCO_SRC_HI 3
`define RCO_SRC_LO 0
`define RCO_SRC_MASK 8'h0f
`define RCO_SRC_RST 8'h00

// ==========================================
// Source codes
`define RCO_SRC_SYS 4'h0
`define RCO_SRC_HFINT 4'h1
`define RCO_SRC_LFINT 4'h2
`define RCO_SRC_MF500 4'h3
`define RCO_SRC_MF31 4'h4
`define RCO_SRC_SEC 4'h5
`define RCO_SRC_NUM 4'h6
`define RCO_SRC_LC1 4'h7
`define RCO_SRC_LC2 4'h8
`define RCO_SRC_LC3 4'h9
`define RCO_SRC_LC4 4'ha

// ==========================================
// Divider and synchroniser sizes
`define RCO_NUM_SRC 10
`define RCO_CNT_W 7

`endif

// >>> rtl/rco_src_sync.v
// Two-flop synchronisers for the asynchronous source clocks.
// Assumes the sources are slower than half the system clock.
`timescale 1ns/1ns
`default_nettype none
`include "rco_consts.vh"

module rco_src_sync (
  input wire sys_clk_i,
  input wire reset_n_i,
  input wire [`RCO_NUM_SRC-1:0] src_async_i,
  output wire [`RCO_NUM_SRC-1:0] src_sync_o
);

  // ==========================================
  // Per-source synchroniser
  genvar g;
  generate
    for (g = 0; g < `RCO_NUM_SRC; g = g + 1) begin : g_sync
      reg meta_r;
      reg sync_r;
      always @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
          meta_r <= 1'b0;
          sync_r <= 1'b0;
        end else begin
          meta_r <= src_async_i[g];
          sync_r <= meta_r;
        end
      end
      assign src_sync_o[g] = sync_r;
    end
  endgenerate

endmodule
`default_nettype wire

// >>> rtl/rco_high_calc.v
// High-time calculator for the duty shaper.
// Assumes divider and duty codes come straight from registers.
`timescale 1ns/1ns
`default_nettype none
`include "rco_consts.vh"

module rco_high_calc (
  input wire [2:0] div_sel_i,
  input wire [1:0] duty_sel_i,
  output reg [7:0] period_o,
  output reg [7:0] high_o
);

  reg [9:0] prod;

  // ==========================================
  // Quarter periods of high time
  always @* begin
    prod = 10'h000;
    period_o = 8'h01 << div_sel_i;
    prod = {2'b00, period_o} * {8'h00, duty_sel_i};
    high_o = prod[9:2];
    if ((duty_sel_i != 2'b00) && (high_o == 8'h00)) begin
      high_o = 8'h01;
    end
  end

endmodule
`default_nettype wire

// >>> rtl/rco_top.v
// Reference clock output block: registers, source select, divider, shaper.
// Assumes a classic Wishbone master on sys_clk_i and asynchronous sources.
`timescale 1ns/1ns
`default_nettype none
`include "rco_consts.vh"

// Behaviour
// - Enable starts output cleanly, no runt
// - Disable stops output at once
// - Divide base clock by two to the code
// - Duty code gives 0, 25, 50, 75 percent; at divide by two, codes 1, 2 and 3 all give 50 percent
// - Undivided base ignores duty, follows base; system clock source gives half rate
// - Duty upper bit resets to one
// - Four-bit code selects base clock source
// - Sleep freezes output at present level
// - Unimplemented bits ignore writes, read zero
// - Enable bit seven, fields reset zero except duty upper bit
// - Divided shaped result drives output pin
module rco_top (
  input wire sys_clk_i,
  input wire reset_n_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [`RCO_ADR_W-1:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire sleep_i,
  input wire high_freq_internal_osc_i,
  input wire low_freq_internal_osc_i,
  input wire mid_freq_internal_osc_500k_i,
  input wire mid_freq_internal_osc_31k_i,
  input wire secondary_osc_i,
  input wire numeric_osc_output_i,
  input wire logic_cell1_output_i,
  input wire logic_cell2_output_i,
  input wire logic_cell3_output_i,
  input wire logic_cell4_output_i,
  output reg ref_clock_out_pin_o,
  output reg ref_clock_out_pin_oe_o,
  output reg refclk_periph_o
);

  // ==========================================
  // Register state
  reg [7:0] ctrl_r;
  reg [7:0] src_r;
  reg [7:0] ctrl_nxt;
  reg [7:0] src_nxt;
  reg [31:0] rdata_nxt;

  wire refclk_module_enable;
  wire [1:0] refclk_duty_sel;
  wire [2:0] refclk_divider_sel;
  wire [3:0] refclk_source_sel;

  assign refclk_module_enable = ctrl_r[`RCO_EN_BIT];
  assign refclk_duty_sel = ctrl_r[`RCO_DUTY_HI:`RCO_DUTY_LO];
  assign refclk_divider_sel = ctrl_r[`RCO_DIV_HI:`RCO_DIV_LO];
  assign refclk_source_sel = src_r[`RCO_SRC_HI:`RCO_SRC_LO];

  // ==========================================
  // Bus request decode
  wire bus_req;
  wire bus_wr;
  wire sel_ctrl;
  wire sel_src;

  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_wr = bus_req & wb_we_i & wb_sel_i[0];
  assign sel_ctrl = (wb_adr_i == `RCO_CTRL_ADR);
  assign sel_src = (wb_adr_i == `RCO_SRC_ADR);

  // ==========================================
  // Register write and read data
  always @* begin
    ctrl_nxt = ctrl_r;
    src_nxt = src_r;
    rdata_nxt = 32'h0000_0000;
    if (bus_wr && sel_ctrl) begin
      ctrl_nxt = wb_dat_i[7:0] & `RCO_CTRL_MASK;
    end
    if (bus_wr && sel_src) begin
      src_nxt = wb_dat_i[7:0] & `RCO_SRC_MASK;
    end
    if (sel_ctrl) begin
      rdata_nxt = {24'h00_0000, ctrl_r};
    end else if (sel_src) begin
      rdata_nxt = {24'h00_0000, src_r};
    end
  end

  always @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      ctrl_r <= `RCO_CTRL_RST;
      src_r <= `RCO_SRC_RST;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      ctrl_r <= ctrl_nxt;
      src_r <= src_nxt;
      wb_ack_o <= bus_req;
      if (bus_req) begin
        wb_dat_o <= rdata_nxt;
      end
    end
  end

  // ==========================================
  // Source synchronisers
  wire [`RCO_NUM_SRC-1:0] src_async;
  wire [`RCO_NUM_SRC-1:0] src_sync;

  assign src_async = {logic_cell4_output_i,
                      logic_cell3_output_i,
                      logic_cell2_output_i,
                      logic_cell1_output_i,
                      numeric_osc_output_i,
                      secondary_osc_i,
                      mid_freq_internal_osc_31k_i,
                      mid_freq_internal_osc_500k_i,
                      low_freq_internal_osc_i,
                      high_freq_internal_osc_i};

  rco_src_sync u_sync (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .src_async_i(src_async),
    .src_sync_o(src_sync)
  );

  // ==========================================
  // Base clock select
  reg base_lvl;
  reg base_is_sys;
  reg base_prev_r;
  wire base_tick;

  always @* begin
    base_lvl = 1'b0;
    base_is_sys = 1'b0;
    case (refclk_source_sel)
      `RCO_SRC_SYS: begin
        base_is_sys = 1'b1;
      end
      `RCO_SRC_HFINT: begin
        base_lvl = src_sync[0];
      end
      `RCO_SRC_LFINT: begin
        base_lvl = src_sync[1];
      end
      `RCO_SRC_MF500: begin
        base_lvl = src_sync[2];
      end
      `RCO_SRC_MF31: begin
        base_lvl = src_sync[3];
      end
      `RCO_SRC_SEC: begin
        base_lvl = src_sync[4];
      end
      `RCO_SRC_NUM: begin
        base_lvl = src_sync[5];
      end
      `RCO_SRC_LC1: begin
        base_lvl = src_sync[6];
      end
      `RCO_SRC_LC2: begin
        base_lvl = src_sync[7];
      end
      `RCO_SRC_LC3: begin
        base_lvl = src_sync[8];
      end
      `RCO_SRC_LC4: begin
        base_lvl = src_sync[9];
      end
      default: begin
        base_lvl = 1'b0;
      end
    endcase
  end

  always @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      base_prev_r <= 1'b0;
    end else if (!sleep_i) begin
      base_prev_r <= base_lvl;
    end
  end

  // Rising edge of the base clock
  assign base_tick = base_is_sys | (base_lvl & ~base_prev_r);

  // ==========================================
  // High-time calculation
  wire [7:0] period;
  wire [7:0] high_cnt;
  wire [`RCO_CNT_W-1:0] last_cnt;

  rco_high_calc u_calc (
    .div_sel_i(refclk_divider_sel),
    .duty_sel_i(refclk_duty_sel),
    .period_o(period),
    .high_o(high_cnt)
  );

  assign last_cnt = period[`RCO_CNT_W-1:0] - {{(`RCO_CNT_W-1){1'b0}}, 1'b1};

  // ==========================================
  // Divider and duty shaper
  reg [`RCO_CNT_W-1:0] cnt_r;
  reg [`RCO_CNT_W-1:0] cnt_nxt;
  reg started_r;
  reg started_nxt;
  reg out_r;
  reg out_nxt;

  // ==========================================
  // Divider helpers
  wire undivided;
  wire period_end;
  wire high_phase;
  wire [`RCO_CNT_W-1:0] cnt_inc;

  assign undivided = (refclk_divider_sel == 3'b000);
  assign period_end = (cnt_r >= last_cnt);
  assign high_phase = ({1'b0, cnt_r} < high_cnt);
  assign cnt_inc = cnt_r + {{(`RCO_CNT_W-1){1'b0}}, 1'b1};

  always @* begin
    cnt_nxt = cnt_r;
    started_nxt = started_r;
    out_nxt = out_r;
    if (!refclk_module_enable) begin
      cnt_nxt = {`RCO_CNT_W{1'b0}};
      started_nxt = 1'b0;
      out_nxt = 1'b0;
    end else if (sleep_i) begin
      out_nxt = out_r;
    end else if (undivided) begin
      if (base_tick || started_r) begin
        started_nxt = 1'b1;
        out_nxt = base_is_sys ? ~out_r : base_lvl;
      end
    end else if (base_tick) begin
      // first high on a period start
      started_nxt = 1'b1;
      out_nxt = high_phase;
      if (period_end) begin
        cnt_nxt = {`RCO_CNT_W{1'b0}};
      end else begin
        cnt_nxt = cnt_inc;
      end
    end
  end

  always @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      cnt_r <= {`RCO_CNT_W{1'b0}};
      started_r <= 1'b0;
      out_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      started_r <= started_nxt;
      out_r <= out_nxt;
    end
  end

  // ==========================================
  // Pin and peripheral outputs
  always @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      ref_clock_out_pin_o <= 1'b0;
      ref_clock_out_pin_oe_o <= 1'b0;
      refclk_periph_o <= 1'b0;
    end else begin
      ref_clock_out_pin_o <= out_nxt;
      ref_clock_out_pin_oe_o <= refclk_module_enable;
      refclk_periph_o <= out_nxt;
    end
  end

endmodule
`default_nettype wire

// >>> rtl/rco_dummy_removed.v
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// >>> verif/rco_top_assertions.sv
// Checker for rco_top: bus answers, register gaps, output clock control.
// Assumes it is bound to rco_top and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
`include "rco_consts.vh"
module rco_top_assertions (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [`RCO_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic sleep_i,
  input wire logic ref_clock_out_pin_o,
  input wire logic ref_clock_out_pin_oe_o,
  input wire logic refclk_periph_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  wire logic rd = wb_ack_o && !wb_we_i;
  wire logic wr_ctrl = wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == `RCO_CTRL_ADR;
  // ==========================================
  // Assertions
  a_ack_answer: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack missing");
  a_ctrl_gaps: assert property (
    rd && wb_adr_i == `RCO_CTRL_ADR |-> wb_dat_o[31:8] == 24'h0 && wb_dat_o[6:5] == 2'h0)
    else $error("control gap bits set");
  a_src_gaps: assert property (
    rd && wb_adr_i == `RCO_SRC_ADR |-> wb_dat_o[31:4] == 28'h0) else $error("source gaps set");
  a_disable_stop: assert property (
    wr_ctrl && !wb_dat_i[7] |=> !ref_clock_out_pin_o) else $error("pin not stopped");
  a_oe_follow: assert property (
    wr_ctrl && wb_dat_i[7] |-> ##2 ref_clock_out_pin_oe_o) else $error("oe not raised");
  a_duty_zero: assert property (
    wr_ctrl && !ref_clock_out_pin_oe_o && wb_dat_i[4:3] == 2'h0 && wb_dat_i[2:0] != 3'h0
    |=> !ref_clock_out_pin_o [*8]) else $error("zero duty pin high");
  a_sleep_hold: assert property (
    sleep_i && $past(sleep_i) && $past(ref_clock_out_pin_oe_o) && ref_clock_out_pin_oe_o
    && !wb_ack_o |-> $stable(ref_clock_out_pin_o)) else $error("pin moved in sleep");
  a_periph_match: assert property (
    refclk_periph_o == ref_clock_out_pin_o) else $error("periph differs from pin");
  c_disable: cover property (wr_ctrl && !wb_dat_i[7] && ref_clock_out_pin_o);
  c_sleep: cover property (sleep_i && ref_clock_out_pin_oe_o);
  c_src_read: cover property (rd && wb_adr_i == `RCO_SRC_ADR);
endmodule
bind rco_top rco_top_assertions chk_u (.sys_clk_i, .reset_n_i, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .sleep_i,
  .ref_clock_out_pin_o, .ref_clock_out_pin_oe_o, .refclk_periph_o);
`default_nettype wire

// >>> verif/rco_clk_sink.sv
// Partner: consumer measuring the output clock in system cycles.
// Assumes pin and enable come from rco_top on the same clock.
`timescale 1ns/1ns
`default_nettype none
module rco_clk_sink (
  input wire logic clk_i,
  input wire logic pin_i,
  input wire logic oe_i,
  output logic [15:0] period_o,
  output logic [15:0] high_o
);
  logic [15:0] cnt_r;
  logic last_r;
  logic seen_r;
  // ==========================================
  // Rise-to-rise and rise-to-fall counts
  // consumes the pin clock
  always @(posedge clk_i) begin
    last_r <= pin_i;
    cnt_r <= cnt_r + 16'h1;
    if (!oe_i) begin
      seen_r <= 1'b0;
      period_o <= 16'h0;
      high_o <= 16'h0;
    end else if (pin_i && !last_r) begin
      if (seen_r) period_o <= cnt_r;
      seen_r <= 1'b1;
      cnt_r <= 16'h1;
    end else if (!pin_i && last_r && seen_r) begin
      high_o <= cnt_r;
    end
  end
endmodule
`default_nettype wire

// >>> verif/rco_top_test.sv
// Testbench for rco_top: registers, divider, duty, disable, sleep, sources.
// Assumes rco_clk_sink as consumer and the bound checker.
`timescale 1ns/1ns
`default_nettype none
`include "rco_consts.vh"
module rco_top_test;
  logic sys_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0;
  logic sleep = 1'b0;
  logic [5:0] sc = 6'h0;
  logic [31:0] rdat;
  logic [7:0] rq;
  logic ack;
  logic pin;
  logic oe;
  logic periph;
  logic [3:0] bsel = 4'hf;
  logic [15:0] per;
  logic [15:0] hi;
  int mismatches = 0;
  int n_compared = 0;
  int cycles = 0;
  always #2 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) sc <= sc + 6'h1;
  rco_top uut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .sleep_i(sleep), .high_freq_internal_osc_i(sc[3]),
    .low_freq_internal_osc_i(sc[4]), .mid_freq_internal_osc_500k_i(sc[3]),
    .mid_freq_internal_osc_31k_i(sc[4]), .secondary_osc_i(sc[3]),
    .numeric_osc_output_i(sc[4]), .logic_cell1_output_i(sc[3]),
    .logic_cell2_output_i(sc[4]), .logic_cell3_output_i(sc[3]),
    .logic_cell4_output_i(sc[4]), .ref_clock_out_pin_o(pin), .ref_clock_out_pin_oe_o(oe),
    .refclk_periph_o(periph));
  rco_clk_sink sink_u (.clk_i(sys_clk_i), .pin_i(pin), .oe_i(oe), .period_o(per), .high_o(hi));
  // ==========================================
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= bsel;
    dat <= {24'h0, d};
    do begin
      @(posedge sys_clk_i);
    end while (ack !== 1'b1);
    chk({31'h0, ack}, 32'h1);
    rq = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge sys_clk_i);
  endtask
  // ==========================================
  // Scenarios
  task automatic t_regs;
    bus(1'b0, `RCO_CTRL_ADR, 8'h00);
    chk({24'h0, rq}, 32'h10);
    bus(1'b0, `RCO_SRC_ADR, 8'h00);
    chk({24'h0, rq}, 32'h00);
    bus(1'b1, `RCO_CTRL_ADR, 8'h7f);
    bus(1'b0, `RCO_CTRL_ADR, 8'h00);
    chk({24'h0, rq}, 32'h1f);
    bsel = 4'he;
    bus(1'b1, `RCO_CTRL_ADR, 8'h80);
    bsel = 4'hf;
    bus(1'b0, `RCO_CTRL_ADR, 8'h00);
    chk({24'h0, rq}, 32'h1f);
    bus(1'b1, `RCO_SRC_ADR, 8'hf0);
    bus(1'b0, `RCO_SRC_ADR, 8'h00);
    chk({24'h0, rq}, 32'h00);
    bus(1'b0, 4'h8, 8'h00);
    chk({24'h0, rq}, 32'h00);
  endtask
  task automatic t_div;
    int n;
    int h;
    for (int v = 0; v < 8; v++) begin
      for (int u = 0; u < 4; u++) begin
        n = (v == 0) ? 2 : (1 << v);
        h = (v == 0) ? 1 : (n * u / 4);
        if (u != 0 && h == 0) h = 1;
        bus(1'b1, `RCO_CTRL_ADR, 8'h00);
        bus(1'b1, `RCO_CTRL_ADR, {1'b1, 2'b00, u[1:0], v[2:0]});
        wt(3 * n + 10);
        chk({16'h0, per}, (v != 0 && u == 0) ? 0 : n);
        chk({16'h0, hi}, h);
      end
    end
  endtask
  task automatic t_disable;
    bus(1'b1, `RCO_CTRL_ADR, 8'h97);
    wt(40);
    chk({31'h0, pin}, 32'h1);
    chk({31'h0, periph}, 32'h1);
    bus(1'b1, `RCO_CTRL_ADR, 8'h17);
    chk({31'h0, pin}, 32'h0);
    chk({31'h0, periph}, 32'h0);
  endtask
  task automatic t_sleep;
    logic p;
    bus(1'b1, `RCO_CTRL_ADR, 8'h93);
    wt(13);
    sleep <= 1'b1;
    wt(2);
    p = pin;
    wt(20);
    chk({31'h0, pin}, {31'h0, p});
    sleep <= 1'b0;
    wt(30);
    chk({16'h0, per}, 32'h8);
  endtask
  task automatic t_src;
    int n;
    for (int c = 0; c < 16; c++) begin
      n = (c == 0) ? 1 : (c > 10) ? 0 : (c % 2) ? 16 : 32;
      bus(1'b1, `RCO_CTRL_ADR, 8'h00);
      bus(1'b1, `RCO_SRC_ADR, c[7:0]);
      bus(1'b1, `RCO_CTRL_ADR, 8'h91);
      wt(200);
      chk({16'h0, per}, 2 * n);
      chk({16'h0, hi}, n);
    end
  endtask
  task automatic t_reset;
    bus(1'b1, `RCO_CTRL_ADR, 8'h00);
    bus(1'b1, `RCO_SRC_ADR, 8'h00);
    bus(1'b1, `RCO_CTRL_ADR, 8'h97);
    wt(5);
    chk({31'h0, oe}, 32'h1);
    reset_n_i <= 1'b0;
    wt(10);
    reset_n_i <= 1'b1;
    wt(1);
    chk({31'h0, pin}, 32'h0);
    chk({31'h0, oe}, 32'h0);
    bus(1'b0, `RCO_CTRL_ADR, 8'h00);
    chk({24'h0, rq}, 32'h10);
    bus(1'b0, `RCO_SRC_ADR, 8'h00);
    chk({24'h0, rq}, 32'h00);
  endtask
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      give_verdict();
    end
  end
  initial begin
    wt(10);
    reset_n_i <= 1'b1;
    wt(3);
    t_regs();
    t_div();
    t_disable();
    t_sleep();
    t_src();
    t_reset();
    give_verdict();
  end
endmodule
`default_nettype wire
